/* src/uram_pkg.sv */
// package for the uart receiver with address match: constants and carriers
// What this block does
// - start a frame only on a 1-to-0 serial input edge while idle
// - sample the serial input at sixteen times the baud rate
// - start edge clears phase counter, presets shift register to 1FFH
// - take three samples at phase states seven, eight and nine
// - bit value is the level seen in at least two of three samples
// - first bit not 0 abandons the frame and resumes edge hunting
// - bits enter a 9-bit register from the left, then one final shift
// - outside 9-bit modes, load only if receive flag is 0 and (multiproc off or stop bit 1)
// - failed load discards the frame, buffer, holder and flag unchanged
// - good load: stop bit (ninth bit in 9-bit modes) to ninth-bit holder, data to buffer, flag set
// - after the final shift return to hunting, loaded or not
// - address recognition is active in 9-bit modes when multiproc enable is set
// - in 9-bit modes with multiproc enable set, flag set only on given or broadcast address match
// - a frame is an address only when its ninth bit is 1
// - given address is address AND mask; mask 0 bits are ignored
// - broadcast is address OR mask; zero bits there are don't-care
// - reset clears slave address and mask to zero so all addresses match
// - mode 1 frame: start 0, eight data bits lsb first, stop 1
package uram_pkg;
    localparam int          DATA_W        = 8;
    localparam int          SHIFT_W       = 9;
    localparam int          PHASE_W       = 4;
    localparam logic [8:0]  SHIFT_PRESET  = 9'h1ff;
    localparam logic [3:0]  SAMPLE_A      = 4'h6;   // seventh state
    localparam logic [3:0]  SAMPLE_B      = 4'h7;   // eighth state
    localparam logic [3:0]  SAMPLE_C      = 4'h8;   // ninth state
    localparam logic [3:0]  PHASE_LAST    = 4'hf;
    localparam logic [7:0]  ADDR_RESET    = 8'h00;
    localparam logic [7:0]  MASK_RESET    = 8'h00;
    localparam logic [1:0]  MODE_SHIFT    = 2'h0;
    localparam logic [1:0]  MODE_8BIT     = 2'h1;
    localparam logic [1:0]  MODE_9BIT_FIX = 2'h2;
    localparam logic [1:0]  MODE_9BIT_VAR = 2'h3;
    localparam int          BUF_DEPTH     = 2;

    typedef enum logic [1:0] {
        URAM_HUNT,
        URAM_START,
        URAM_DATA
    } uram_state_e;

    // one received frame as it passes through the buffer
    typedef struct packed {
        logic       ninth;
        logic [7:0] data;
    } uram_frame_s;
endpackage : uram_pkg

/* src/uram_fifo.sv */
// two-entry buffer carrying received frames toward the receive buffer
`timescale 1ns/1ns
module uram_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 2
) (
    input  wire logic             clock_in,
    input  wire logic             rst_b_in,
    input  wire logic             wr_valid_in,
    output logic                  wr_ready_out,
    input  wire logic [WIDTH-1:0] wr_data_in,
    output logic                  rd_valid_out,
    input  wire logic             rd_ready_in,
    output logic      [WIDTH-1:0] rd_data_out
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wptr_q;
    logic [AW-1:0]    rptr_q;
    logic [AW:0]      count_q;
    logic             push;
    logic             pop;

    assign wr_ready_out = (count_q != (AW+1)'(DEPTH));
    assign rd_valid_out = (count_q != '0);
    assign push         = wr_valid_in && wr_ready_out;
    assign pop          = rd_valid_out && rd_ready_in;
    assign rd_data_out  = mem_q[rptr_q];

    // storage has no reset; only pointers and count need a defined start
    always_ff @(posedge clock_in) begin
        if (push) begin
            mem_q[wptr_q] <= wr_data_in;
        end
    end

    // pointers wrap at depth, count tracks occupancy
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wptr_q  <= '0;
            rptr_q  <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wptr_q <= (wptr_q == AW'(DEPTH-1)) ? '0 : wptr_q + 1'b1;
            end
            if (pop) begin
                rptr_q <= (rptr_q == AW'(DEPTH-1)) ? '0 : rptr_q + 1'b1;
            end
            count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : uram_fifo

/* src/uram_rx.sv */
// receive path of the serial port with hardware address recognition
`timescale 1ns/1ns
module uram_rx #(
    parameter int DATA_W = uram_pkg::DATA_W
) (
    input  wire logic              clock_in,
    input  wire logic              rst_b_in,
    input  wire logic              tick16_in,
    input  wire logic              serial_rx_in,
    input  wire logic [1:0]        mode_in,
    input  wire logic              multiproc_enable_in,
    input  wire logic              receive_enable_in,
    input  wire logic [DATA_W-1:0] slave_address_in,
    input  wire logic [DATA_W-1:0] slave_address_mask_in,
    input  wire logic              addr_write_in,
    input  wire logic              receive_flag_clear_in,
    output logic                   receive_flag_out,
    output logic [DATA_W-1:0]      receive_buffer_out,
    output logic                   ninth_bit_holder_out,
    output logic                   busy_out,
    output logic                   frame_lost_out
);
    logic              rst_s1_q;
    logic              rst_s2_q;
    logic              rx_m1_q;
    logic              rx_m2_q;
    logic              rx_m3_q;
    logic              rx_q;
    uram_pkg::uram_state_e state_q;
    uram_pkg::uram_state_e state_d;
    logic [3:0]        phase_q;
    logic [1:0]        votes_q;
    logic [8:0]        shift_q;
    logic [3:0]        bits_q;
    logic [DATA_W-1:0] addr_q;
    logic [DATA_W-1:0] mask_q;
    logic              flag_q;
    logic [DATA_W-1:0] rbuf_q;
    logic              rb8_q;
    logic              busy_q;
    logic              lost_q;
    logic              armed_q;

    // reset release through two flops; the async edge only clears
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end

    wire rst_b = rst_s2_q;

    // pin synchroniser: three flops, level changes only when 2 and 3 agree
    always_ff @(posedge clock_in or negedge rst_b) begin
        if (!rst_b) begin
            rx_m1_q <= 1'b1;
            rx_m2_q <= 1'b1;
            rx_m3_q <= 1'b1;
            rx_q    <= 1'b1;
        end else begin
            rx_m1_q <= serial_rx_in;
            rx_m2_q <= rx_m1_q;
            rx_m3_q <= rx_m2_q;
            if (rx_m2_q == rx_m3_q) begin
                rx_q <= rx_m3_q;
            end
        end
    end

    // decode of sample points, votes and frame position
    wire       ninebit    = (mode_in == uram_pkg::MODE_9BIT_FIX) ||
                            (mode_in == uram_pkg::MODE_9BIT_VAR);
    wire       is_sample  = (phase_q == uram_pkg::SAMPLE_A) ||
                            (phase_q == uram_pkg::SAMPLE_B) ||
                            (phase_q == uram_pkg::SAMPLE_C);
    wire [1:0] vote_sum   = votes_q + {1'b0, rx_q};
    wire       bit_val    = (vote_sum >= 2'h2);
    wire       bit_end    = tick16_in && (phase_q == uram_pkg::SAMPLE_C);
    // gating with armed here keeps busy from flickering on a held low line
    wire       start_edge = tick16_in && !rx_q && receive_enable_in &&
                            armed_q;
    // frame length counts start, data, optional ninth bit and stop
    wire [3:0] last_bit   = ninebit ? 4'hb : 4'ha;
    wire       final_bit  = bits_q == last_bit - 4'h1;
    wire [8:0] shift_next = {bit_val, shift_q[8:1]};

    // data sit below the ninth bit in 9-bit modes, above the start in mode 1
    wire [7:0] rx_data    = ninebit ? shift_q[7:0] : shift_q[8:1];
    // the ninth bit is already at the top; mode 1 takes the stop bit
    wire       rx_ninth   = ninebit ? shift_q[8] : bit_val;
    // address match: given and broadcast comparisons
    wire [7:0] given_care = mask_q;
    wire       given_hit  = ((rx_data ^ addr_q) & given_care) == 8'h00;
    wire [7:0] bcast      = addr_q | mask_q;
    wire       bcast_hit  = ((~rx_data) & bcast) == 8'h00;
    wire       addr_frame = rx_ninth;
    wire       filter_on  = multiproc_enable_in && ninebit;
    wire       addr_ok    = !filter_on ||
                            (addr_frame && (given_hit || bcast_hit));
    // mode 1 filter: with multiproc on, a stop bit of 1 is required
    wire       stop_ok    = !multiproc_enable_in || rx_ninth;
    wire       mode_ok    = ninebit ? addr_ok : stop_ok;
    wire       frame_done = (state_q == uram_pkg::URAM_DATA) && bit_end &&
                            final_bit;
    wire       load_ok    = !flag_q && mode_ok;
    wire       fifo_wr    = frame_done && load_ok;
    wire       fifo_ready;
    wire       fifo_valid;
    uram_pkg::uram_frame_s fifo_in;
    uram_pkg::uram_frame_s fifo_out;

    assign fifo_in.ninth = rx_ninth;
    assign fifo_in.data  = rx_data;

    // phase counter: cleared on the start edge, steps only on the tick
    always_ff @(posedge clock_in or negedge rst_b) begin
        if (!rst_b) begin
            phase_q <= 4'h0;
        end else if (state_q == uram_pkg::URAM_HUNT) begin
            phase_q <= 4'h0;
        end else if (tick16_in) begin
            phase_q <= phase_q + 4'h1;
        end
    end

    // majority vote accumulator, restarted each bit time
    always_ff @(posedge clock_in or negedge rst_b) begin
        if (!rst_b) begin
            votes_q <= 2'h0;
        end else if (state_q == uram_pkg::URAM_HUNT) begin
            // stale votes from the last stop bit would reject the next start
            votes_q <= 2'h0;
        end else if (tick16_in && phase_q == uram_pkg::PHASE_LAST) begin
            votes_q <= 2'h0;
        end else if (tick16_in && is_sample &&
                     phase_q != uram_pkg::SAMPLE_C) begin
            votes_q <= vote_sum;
        end
    end

    // frame sequencer
    always_comb begin
        state_d = state_q;
        case (state_q)
            uram_pkg::URAM_HUNT: begin
                if (start_edge) begin
                    state_d = uram_pkg::URAM_START;
                end
            end
            uram_pkg::URAM_START: begin
                if (bit_end) begin
                    state_d = bit_val ? uram_pkg::URAM_HUNT
                                      : uram_pkg::URAM_DATA;
                end
            end
            uram_pkg::URAM_DATA: begin
                if (frame_done) begin
                    state_d = uram_pkg::URAM_HUNT;
                end
            end
            default: begin
                state_d = uram_pkg::URAM_HUNT;
            end
        endcase
    end

    // hunting needs a high line first so a held low is no edge
    always_ff @(posedge clock_in or negedge rst_b) begin
        if (!rst_b) begin
            armed_q <= 1'b0;
        end else if (state_q != uram_pkg::URAM_HUNT) begin
            armed_q <= 1'b0;
        end else if (rx_q) begin
            armed_q <= 1'b1;
        end
    end

    always_ff @(posedge clock_in or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= uram_pkg::URAM_HUNT;
        end else begin
            state_q <= state_d;
        end
    end

    // input shift register and bit counter
    always_ff @(posedge clock_in or negedge rst_b) begin
        if (!rst_b) begin
            shift_q <= uram_pkg::SHIFT_PRESET;
            bits_q  <= 4'h0;
        end else if (state_q == uram_pkg::URAM_HUNT) begin
            shift_q <= uram_pkg::SHIFT_PRESET;
            bits_q  <= 4'h0;
        end else if (bit_end) begin
            shift_q <= shift_next;
            bits_q  <= bits_q + 4'h1;
        end
    end

    // frames pass through a two-entry buffer, but only frames ending while the flag is
    // clear enter it, others are lost; words only leave it while the flag is clear
    uram_fifo #(
        .WIDTH ($bits(uram_pkg::uram_frame_s)),
        .DEPTH (uram_pkg::BUF_DEPTH)
    ) u_fifo (
        .clock_in     (clock_in),
        .rst_b_in     (rst_b),
        .wr_valid_in  (fifo_wr),
        .wr_ready_out (fifo_ready),
        .wr_data_in   (fifo_in),
        .rd_valid_out (fifo_valid),
        .rd_ready_in  (!flag_q),
        .rd_data_out  (fifo_out)
    );

    wire pop     = fifo_valid && !flag_q;
    wire dropped = frame_done && !(load_ok && fifo_ready);

    // receive buffer, ninth-bit holder and flag; a new load beats a clear
    always_ff @(posedge clock_in or negedge rst_b) begin
        if (!rst_b) begin
            flag_q <= 1'b0;
            rbuf_q <= 8'h00;
            rb8_q  <= 1'b0;
        end else if (pop) begin
            rbuf_q <= fifo_out.data;
            rb8_q  <= fifo_out.ninth;
            flag_q <= 1'b1;
        end else if (receive_flag_clear_in) begin
            flag_q <= 1'b0;
        end
    end

    // slave address and mask, cleared at reset so every address matches
    always_ff @(posedge clock_in or negedge rst_b) begin
        if (!rst_b) begin
            addr_q <= uram_pkg::ADDR_RESET;
            mask_q <= uram_pkg::MASK_RESET;
        end else if (addr_write_in) begin
            addr_q <= slave_address_in;
            mask_q <= slave_address_mask_in;
        end
    end

    // status outputs straight from flops
    always_ff @(posedge clock_in or negedge rst_b) begin
        if (!rst_b) begin
            busy_q <= 1'b0;
            lost_q <= 1'b0;
        end else begin
            busy_q <= (state_d != uram_pkg::URAM_HUNT);
            lost_q <= dropped;
        end
    end

    assign receive_flag_out     = flag_q;
    assign receive_buffer_out   = rbuf_q;
    assign ninth_bit_holder_out = rb8_q;
    assign busy_out             = busy_q;
    assign frame_lost_out       = lost_q;
endmodule : uram_rx

/* test/uram_line_src.sv */
// serial line source standing in for the far node
`timescale 1ns/1ns
module uram_line_src (
    input  wire logic clock_in,
    input  wire logic tick16_in,
    output logic      serial_rx_out
);
    // a real sender leaves the line high between frames
    initial serial_rx_out = 1'b1;

    // wait for the next oversampling tick, then move off the edge
    task automatic next_tick;
        do @(posedge clock_in); while (tick16_in !== 1'b1);
        @(negedge clock_in);
    endtask : next_tick

    // lsb first, sixteen ticks a bit; bit gl gets one inverted tick
    task automatic send(input logic [10:0] bits, input int n, input int gl);
        serial_rx_out = 1'b1;
        // idle first so the receiver sees high before the start edge
        repeat (3) next_tick();
        for (int b = 0; b < n; b++) begin
            for (int t = 0; t < 16; t++) begin
                serial_rx_out = (b == gl && t == 8) ? ~bits[b] : bits[b];
                next_tick();
            end
        end
        serial_rx_out = 1'b1;
    endtask : send
endmodule : uram_line_src

/* test/uram_rx_monitor.sv */
// concurrent checks on the receiver ports
`timescale 1ns/1ns
module uram_rx_monitor #(
    parameter int DATA_W = uram_pkg::DATA_W
) (
    input wire logic              clock_in,
    input wire logic              rst_b_in,
    input wire logic              tick16_in,
    input wire logic              serial_rx_in,
    input wire logic [1:0]        mode_in,
    input wire logic              multiproc_enable_in,
    input wire logic              receive_enable_in,
    input wire logic [DATA_W-1:0] slave_address_in,
    input wire logic [DATA_W-1:0] slave_address_mask_in,
    input wire logic              addr_write_in,
    input wire logic              receive_flag_clear_in,
    input wire logic              receive_flag_out,
    input wire logic [DATA_W-1:0] receive_buffer_out,
    input wire logic              ninth_bit_holder_out,
    input wire logic              busy_out,
    input wire logic              frame_lost_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);

    // a discarded frame is reported by a single pulse
    a_lost_one_pulse: assert property (frame_lost_out |=> !frame_lost_out)
        else $error("lost pulse longer than one cycle");
    // a held word is never overwritten while the flag stands
    a_flag_holds_data: assert property (receive_flag_out && !receive_flag_clear_in
        |=> receive_flag_out && $stable(receive_buffer_out)
            && $stable(ninth_bit_holder_out))
        else $error("held word changed while flag set");
    a_clear_drops_flag: assert property (receive_flag_clear_in && receive_flag_out
        |=> !receive_flag_out)
        else $error("flag not cleared");
    // loads come two cycles after a tick that ended a frame
    a_load_after_tick: assert property ($rose(receive_flag_out)
        |-> $past(tick16_in, 2) && $past(busy_out, 2))
        else $error("flag rose outside a frame end");
    a_lost_after_frame: assert property ($rose(frame_lost_out)
        |-> $past(busy_out) || $past(busy_out, 2))
        else $error("lost pulse without a frame");
    // sync delay of the line is a few cycles, hence the small window
    a_start_on_low: assert property ($rose(busy_out)
        |-> ($past(tick16_in) || $past(tick16_in, 2)) && $past(receive_enable_in)
            && (!$past(serial_rx_in, 3) || !$past(serial_rx_in, 4)
                || !$past(serial_rx_in, 5) || !$past(serial_rx_in, 6)))
        else $error("frame started without a low line");
    a_stop_gates_load: assert property ($rose(receive_flag_out)
        && multiproc_enable_in && !mode_in[1] |-> ninth_bit_holder_out)
        else $error("bad stop bit loaded under filter");
    a_address_ninth: assert property ($rose(receive_flag_out)
        && multiproc_enable_in && mode_in[1] |-> ninth_bit_holder_out)
        else $error("data frame loaded under filter");
    a_lost_when_full: assert property ($rose(frame_lost_out)
        && !multiproc_enable_in |-> $past(receive_flag_out))
        else $error("frame lost with flag clear");

    c_load: cover property ($rose(receive_flag_out));
    c_lost: cover property ($rose(frame_lost_out));
    c_nine: cover property ($rose(busy_out) && mode_in[1]);
endmodule : uram_rx_monitor

/* test/uram_rx_addr_match_tb_top.sv */
// self-checking bench for the receiver with address recognition
`timescale 1ns/1ns
module uart_receiver_addr_match_tb_top;
    logic       clock_in = 1'b0;
    logic       rst_b_in = 1'b0;
    logic       tick_q   = 1'b0;
    logic [1:0] mode     = 2'h1;
    logic       mp_en    = 1'b0;
    logic       rx_en    = 1'b1;
    logic       wr       = 1'b0;
    logic       clr      = 1'b0;
    logic [7:0] addr     = 8'h00;
    logic [7:0] mask     = 8'h00;
    logic       line;
    logic       flag, ninth, busy, lost;
    logic [7:0] buff;
    int         bad_count = 0;
    int         n_compared = 0;
    int         lost_n = 0;
    int         cnt = 0;
    // bench model state; address copies clear to zero like the device
    logic       m_flag = 1'b0;
    logic       m_ninth = 1'b0;
    logic [7:0] m_buf = 8'h00;
    logic [7:0] m_addr = 8'h00;
    logic [7:0] m_mask = 8'h00;
    int         m_lost = 0;
    logic [7:0] alist [8] = '{8'hc0, 8'hc6, 8'hc1, 8'hc8,
                              8'hff, 8'hf9, 8'h3f, 8'h00};

    initial forever #25 clock_in = ~clock_in;
    // one-cycle tick every four clocks keeps frames short
    always @(negedge clock_in) begin
        cnt <= (cnt + 1) % 4;
        tick_q <= (cnt == 3);
    end
    // count lost pulses where they are settled, away from the launch edge
    always @(negedge clock_in) if (lost === 1'b1) lost_n++;

    uram_rx i_dut (.clock_in(clock_in), .rst_b_in(rst_b_in),
        .tick16_in(tick_q), .serial_rx_in(line), .mode_in(mode),
        .multiproc_enable_in(mp_en), .receive_enable_in(rx_en),
        .slave_address_in(addr), .slave_address_mask_in(mask),
        .addr_write_in(wr), .receive_flag_clear_in(clr),
        .receive_flag_out(flag), .receive_buffer_out(buff),
        .ninth_bit_holder_out(ninth), .busy_out(busy),
        .frame_lost_out(lost));
    uram_line_src i_src (.clock_in(clock_in), .tick16_in(tick_q),
        .serial_rx_out(line));

    task automatic check(input string what, input logic [8:0] seen,
                         input logic [8:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic give_verdict;
        $display("mismatches %0d, compared %0d", bad_count, n_compared);
        if (bad_count == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : give_verdict

    function automatic logic hit(input logic [7:0] d);
        hit = (((d ^ m_addr) & m_mask) == 8'h00)
            || ((~d & (m_addr | m_mask)) == 8'h00);
    endfunction : hit

    task automatic wait_idle;
        int i;
        i = 0;
        while (busy !== 1'b0 && i < 4000) begin
            @(negedge clock_in);
            i++;
        end
        if (i >= 4000) begin
            bad_count++;
            give_verdict();
        end
        repeat (4) @(negedge clock_in);
    endtask : wait_idle

    task automatic compare_all;
        check("flag", {8'h00, flag}, {8'h00, m_flag});
        check("buffer", {1'b0, buff}, {1'b0, m_buf});
        check("holder", {8'h00, ninth}, {8'h00, m_ninth});
        check("lost", 9'(lost_n), 9'(m_lost));
    endtask : compare_all

    // send one frame and move the model as the load condition says
    task automatic frame(input logic [7:0] d, input logic b9,
                         input logic stop, input int gl);
        logic ok;
        ok = !m_flag && (!mp_en || (mode[1] ? b9 && hit(d) : stop));
        i_src.send(mode[1] ? {stop, b9, d, 1'b0} : {1'b1, stop, d, 1'b0},
                   mode[1] ? 11 : 10, gl);
        if (rx_en && ok) begin
            m_flag = 1'b1;
            m_buf = d;
            m_ninth = mode[1] ? b9 : stop;
        end else if (rx_en) begin
            m_lost++;
        end
        wait_idle();
        compare_all();
    endtask : frame

    task automatic clear_flag;
        clr = 1'b1;
        @(negedge clock_in);
        clr = 1'b0;
        @(negedge clock_in);
        m_flag = 1'b0;
        check("cleared", {8'h00, flag}, 9'h000);
    endtask : clear_flag

    // guard against a hang anywhere in the run
    initial begin
        #4000000;
        bad_count++;
        give_verdict();
    end

    initial begin
        void'($urandom(32'h0b2d_d795));
        repeat (3) @(negedge clock_in);
        rst_b_in = 1'b1;
        repeat (6) @(negedge clock_in);
        compare_all();
        // every mode without filtering, random data and ninth bit
        for (int k = 0; k < 8; k++) begin
            mode = 2'(k % 4);
            frame(8'($urandom), 1'($urandom), 1'b1, -1);
            clear_flag();
        end
        mode = 2'h1;
        frame(8'h5a, 1'b1, 1'b1, -1);
        frame(8'ha5, 1'b1, 1'b1, -1);
        clear_flag();
        // one inverted sample in a data bit is outvoted
        frame(8'h3c, 1'b1, 1'b1, 3);
        clear_flag();
        // short low pulse on an idle line is a false start
        i_src.send(11'h7ff, 3, 0);
        wait_idle();
        compare_all();
        rx_en = 1'b0;
        frame(8'h0f, 1'b1, 1'b1, -1);
        rx_en = 1'b1;
        mp_en = 1'b1;
        frame(8'h11, 1'b1, 1'b0, -1);
        frame(8'h22, 1'b1, 1'b1, -1);
        clear_flag();
        // reset address and mask match all; data frames are refused
        mode = 2'h2;
        frame(8'($urandom), 1'b1, 1'b1, -1);
        clear_flag();
        frame(8'h00, 1'b0, 1'b1, -1);
        addr = 8'hc0;
        mask = 8'hf9;
        wr = 1'b1;
        @(negedge clock_in);
        wr = 1'b0;
        m_addr = addr;
        m_mask = mask;
        alist[7] = 8'($urandom);
        for (int k = 0; k < 8; k++) begin
            mode = k[0] ? 2'h3 : 2'h2;
            frame(alist[k], 1'b1, 1'b1, -1);
            if (m_flag) clear_flag();
        end
        give_verdict();
    end
endmodule : uart_receiver_addr_match_tb_top

// checker beside the receiver ports
bind uram_rx uram_rx_monitor #(.DATA_W(DATA_W)) i_mon (.clock_in,
    .rst_b_in, .tick16_in, .serial_rx_in, .mode_in, .multiproc_enable_in,
    .receive_enable_in, .slave_address_in, .slave_address_mask_in,
    .addr_write_in, .receive_flag_clear_in, .receive_flag_out,
    .receive_buffer_out, .ninth_bit_holder_out, .busy_out,
    .frame_lost_out);
